// >>> hdl/mas_alert_gpio.sv
// Status, fault and alert logic with three-pin function configuration.
`timescale 1ns/1ps
module mas_alert_gpio
  import mas_pkg::*;
(
  // Clock and reset
  input  wire logic              core_clk,
  input  wire logic              rst_n,
  // Host register port
  input  wire logic [7:0]        reg_addr,
  input  wire logic              reg_wr,
  input  wire logic [7:0]        reg_wdata,
  input  wire logic              reg_rd,
  output logic      [7:0]        reg_rdata,
  output logic                   reg_rvalid,
  // Measurement core
  input  wire logic [7:0]        limit_compare,
  input  wire mas_event_type     core_event,
  output logic                   shutdown,
  output logic                   accumulate_enable,
  output logic                   alert_pulse,
  // Pins
  input  wire logic              pin_one_in,
  input  wire logic              pin_two_in,
  input  wire logic              pin_three_in,
  output mas_pin_drive_type      pin_one,
  output mas_pin_drive_type      pin_two,
  output mas_pin_drive_type      pin_three
);

  logic [7:0]        limit_status_bits;
  logic [7:0]        limit_fault_bits;
  logic [7:0]        event_alert_enable_bits;
  logic [7:0]        pin_function_bits;
  logic [7:0]        ctrl_b_bits;
  logic              alert_generated_flag;
  logic              pin_three_pull;
  logic              wake_event;
  logic              pin_one_active;
  logic              pin_two_active;
  logic              alert_now;
  mas_pin_mode_type  mode_one;
  mas_pin_mode_type  mode_two;
  mas_pin_mode_type  mode_three;

  function automatic logic pin_active(input mas_pin_mode_type mode,
                                      input logic level);
    logic act;
    act = 1'b0;
    case (mode)
      MAS_PIN_IN_HIGH: act = level;
      MAS_PIN_IN_LOW:  act = ~level;
      default:         act = 1'b0;
    endcase
    return act;
  endfunction : pin_active

  function automatic logic wr_hit(input logic [7:0] addr);
    return reg_wr && (reg_addr == addr);
  endfunction : wr_hit

  assign mode_one   =
      mas_pin_mode_type'(pin_function_bits[MAS_GP1_HI:MAS_GP1_LO]);
  assign mode_two   =
      mas_pin_mode_type'(pin_function_bits[MAS_GP2_HI:MAS_GP2_LO]);
  assign mode_three =
      mas_pin_mode_type'(pin_function_bits[MAS_GP3_HI:MAS_GP3_LO]);

  assign pin_one_active = pin_active(mode_one, pin_one_in);
  assign pin_two_active = pin_active(mode_two, pin_two_in);

  assign wake_event = core_event.stuck_timeout && ctrl_b_bits[MAS_CB_SHUTDOWN]
                      && ctrl_b_bits[MAS_CB_WAKE_EN];

  // energy overflow, charge overflow, time overflow.
  assign alert_now =
      (event_alert_enable_bits[MAS_AL_CONV] && core_event.conv_done)
    || (event_alert_enable_bits[MAS_AL_PIN1] && pin_one_active)
    || (event_alert_enable_bits[MAS_AL_PIN2] && pin_two_active)
    || (event_alert_enable_bits[MAS_AL_WAKE] && wake_event)
    || (event_alert_enable_bits[MAS_AL_ENRG] && core_event.energy_ovf)
    || (event_alert_enable_bits[MAS_AL_CHRG] && core_event.charge_ovf)
    || (event_alert_enable_bits[MAS_AL_TIME] && core_event.time_ovf);

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      limit_status_bits <= MAS_RST_BYTE;
    end else begin
      limit_status_bits <= limit_compare;
    end
  end

  // host overwrite, aux bits; a new crossing wins over the write.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      limit_fault_bits <= MAS_RST_BYTE;
    end else if (wr_hit(MAS_ADDR_FAULT)) begin
      limit_fault_bits <= reg_wdata | limit_compare;
    end else begin
      limit_fault_bits <= limit_fault_bits | limit_compare;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      event_alert_enable_bits <= MAS_RST_BYTE;
    end else if (wr_hit(MAS_ADDR_ALERT_EN)) begin
      event_alert_enable_bits <= reg_wdata & MAS_AL_WRITABLE;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pin_function_bits <= MAS_RST_BYTE;
    end else if (wr_hit(MAS_ADDR_PIN_CFG)) begin
      pin_function_bits <= reg_wdata & MAS_GP_WRITABLE;
    end
  end

  // leave shutdown
  // Only the shutdown bit is touched by hardware; the rest is host owned.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ctrl_b_bits <= MAS_RST_BYTE;
    end else begin
      if (wr_hit(MAS_ADDR_CTRL_B)) begin
        ctrl_b_bits <= reg_wdata;
      end
      if (wake_event) begin
        ctrl_b_bits[MAS_CB_SHUTDOWN] <= 1'b0;
      end
    end
  end

  // sticky alert flag
  // Setting by a generated alert wins over a host write of zero.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      alert_generated_flag <= 1'b0;
      pin_three_pull       <= 1'b0;
    end else begin
      if (wr_hit(MAS_ADDR_PIN3_CTL)) begin
        alert_generated_flag <= reg_wdata[MAS_GC_ALERT] | alert_now;
        pin_three_pull       <= reg_wdata[MAS_GC_PULL];
      end else if (alert_now) begin
        alert_generated_flag <= 1'b1;
      end
    end
  end

  // Core-facing outputs, registered.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      shutdown          <= 1'b0;
      accumulate_enable <= 1'b0;
      alert_pulse       <= 1'b0;
    end else begin
      shutdown <= ctrl_b_bits[MAS_CB_SHUTDOWN];
      accumulate_enable <= (ctrl_b_bits[MAS_CB_ACC_HI:MAS_CB_ACC_LO]
                            == MAS_ACC_FOLLOW_GATE)
                           && (mode_two == MAS_PIN_SPECIAL) && pin_two_in;
      alert_pulse <= alert_now;
    end
  end

  // Pins are open drain: they only ever pull low, so out is held at zero.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pin_one   <= '0;
      pin_two   <= '0;
      pin_three <= '0;
    end else begin
      pin_one.oe <= (mode_one == MAS_PIN_SPECIAL);
      pin_two.oe <= (mode_two == MAS_PIN_OUT_A)
                    && pin_function_bits[MAS_GP2_OUT];
      pin_three.oe <= ((mode_three == MAS_PIN_SPECIAL)
                       && alert_generated_flag)
                      || ((mode_three == MAS_PIN_OUT_A) && pin_three_pull);
      pin_one.out   <= 1'b0;
      pin_two.out   <= 1'b0;
      pin_three.out <= 1'b0;
    end
  end

  // Read path: one cycle of latency, unmapped addresses read zero.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      reg_rdata  <= MAS_RST_BYTE;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        case (reg_addr)
          MAS_ADDR_CTRL_B:   reg_rdata <= ctrl_b_bits;
          MAS_ADDR_STATUS:   reg_rdata <= limit_status_bits;
          MAS_ADDR_FAULT:    reg_rdata <= limit_fault_bits;
          MAS_ADDR_ALERT_EN: reg_rdata <= event_alert_enable_bits;
          MAS_ADDR_PIN_CFG:  reg_rdata <= pin_function_bits;
          MAS_ADDR_PIN3_CTL: reg_rdata <= {alert_generated_flag,
                                           pin_three_pull, 6'h00};
          default:           reg_rdata <= MAS_RST_BYTE;
        endcase
      end
    end
  end

  // Pin three input is not used by this block; it only feeds an unused net.
  logic unused_pin_three;
  assign unused_pin_three = pin_three_in;

endmodule : mas_alert_gpio

// >>> hdl/mas_pkg.sv
// Package with register map, field positions and types of the alert block.
// What this block does
// - Limit status byte: power, sense current, input voltage, aux over/under.
// - Limit fault byte, same bit order, one means condition occurred.
// - Host reads and overwrites the fault byte at its own address.
// - Aux voltage fault bits set on over (bit 1) or under (bit 0).
// - Second alert enable byte is read/write and resets to all zero.
// - Enable bit 7 raises an alert on each completed conversion.
// - Enable bit 6 raises an alert while pin one input is active.
// - Enable bit 5 alerts while pin two input is active; bit 4 reserved.
// - Enable bit 3 raises alert on stuck-bus timeout wake-up from shutdown.
// - Enable bit 2 raises an alert on energy accumulator overflow.
// - Enable bit 1 raises an alert on charge accumulator overflow.
// - Enable bit 0 raises an alert on elapsed-time counter overflow.
// - Pin one field: 11 in high, 10 in low, 01 hi-z, 00 pull low.
// - Pin two field: 11 in high, 10 in low, 01 output, 00 gate input.
// - Pin two output bit pulls pin low when one, only in output mode.
// - Pin three as alert pulls low while flag set; writing 0 clears it.
// - Stuck-bus wake-up enable lets device leave shutdown on timer expiry.
// - Gate-follow mode makes accumulation follow pin two gate input.
package mas_pkg;

  // Register addresses on the host register port.
  localparam logic [7:0] MAS_ADDR_CTRL_B   = 8'h01;
  localparam logic [7:0] MAS_ADDR_STATUS   = 8'h03;
  localparam logic [7:0] MAS_ADDR_FAULT    = 8'h04;
  localparam logic [7:0] MAS_ADDR_ALERT_EN = 8'h32;
  localparam logic [7:0] MAS_ADDR_PIN_CFG  = 8'h33;
  localparam logic [7:0] MAS_ADDR_PIN3_CTL = 8'h42;

  // Reset values.
  localparam logic [7:0] MAS_RST_BYTE = 8'h00;

  // Control register field positions.
  localparam int MAS_CB_SHUTDOWN = 6;
  localparam int MAS_CB_WAKE_EN  = 4;
  localparam int MAS_CB_ACC_HI   = 3;
  localparam int MAS_CB_ACC_LO   = 2;
  localparam logic [1:0] MAS_ACC_FOLLOW_GATE = 2'h2;

  // Alert enable field positions.
  localparam int MAS_AL_CONV  = 7;
  localparam int MAS_AL_PIN1  = 6;
  localparam int MAS_AL_PIN2  = 5;
  localparam int MAS_AL_WAKE  = 3;
  localparam int MAS_AL_ENRG  = 2;
  localparam int MAS_AL_CHRG  = 1;
  localparam int MAS_AL_TIME  = 0;
  localparam logic [7:0] MAS_AL_WRITABLE = 8'hEF;

  // Pin configuration field positions.
  localparam int MAS_GP1_HI = 7;
  localparam int MAS_GP1_LO = 6;
  localparam int MAS_GP2_HI = 5;
  localparam int MAS_GP2_LO = 4;
  localparam int MAS_GP3_HI = 3;
  localparam int MAS_GP3_LO = 2;
  localparam int MAS_GP2_OUT = 1;
  localparam logic [7:0] MAS_GP_WRITABLE = 8'hFE;

  // Pin three control field positions.
  localparam int MAS_GC_ALERT = 7;
  localparam int MAS_GC_PULL  = 6;
  localparam logic [7:0] MAS_GC_WRITABLE = 8'hC0;

  // Pin function encodings.
  typedef enum logic [1:0] {
    MAS_PIN_IN_HIGH = 2'b11,
    MAS_PIN_IN_LOW  = 2'b10,
    MAS_PIN_OUT_A   = 2'b01,
    MAS_PIN_SPECIAL = 2'b00
  } mas_pin_mode_type;

  // One-cycle event pulses from the measurement core.
  typedef struct packed {
    logic conv_done;
    logic stuck_timeout;
    logic energy_ovf;
    logic charge_ovf;
    logic time_ovf;
  } mas_event_type;

  // One open-drain pin as seen at the design port.
  typedef struct packed {
    logic out;
    logic oe;
  } mas_pin_drive_type;

endpackage : mas_pkg

// >>> bench/mas_alert_gpio_sva.sv
// Checker for the register port and pin drive of the alert block.
`timescale 1ns/1ps
module mas_alert_chk
  import mas_pkg::*;
(
  // Clock and reset
  input wire logic          core_clk,
  input wire logic          rst_n,
  // Register port
  input wire logic [7:0]    reg_addr,
  input wire logic          reg_wr,
  input wire logic [7:0]    reg_wdata,
  input wire logic          reg_rd,
  input wire logic [7:0]    reg_rdata,
  input wire logic          reg_rvalid,
  // Core side
  input wire logic [7:0]    limit_compare,
  input wire mas_event_type core_event,
  input wire logic          shutdown,
  input wire logic          accumulate_enable,
  input wire logic          alert_pulse,
  // Pins
  input wire logic          pin_one_in,
  input wire logic          pin_two_in,
  input wire logic          pin_three_in,
  input mas_pin_drive_type  pin_one,
  input mas_pin_drive_type  pin_two,
  input mas_pin_drive_type  pin_three
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  AST_RVALID:
    assert property (reg_rd |=> reg_rvalid) else $error("no read answer");
  AST_RVALID_ONE:
    assert property (!reg_rd |=> !reg_rvalid) else $error("stray rvalid");
  AST_RDATA_HOLD:
    assert property (!$past(reg_rd) |-> $stable(reg_rdata))
      else $error("read data moved");
  AST_STATUS:
    assert property (reg_rd && reg_addr == MAS_ADDR_STATUS
      |=> reg_rdata == $past(limit_compare, 2)) else $error("bad status");
  AST_FAULT_SET:
    assert property (reg_rd && reg_addr == MAS_ADDR_FAULT
      |=> (reg_rdata & $past(limit_compare, 2)) == $past(limit_compare, 2))
      else $error("fault bit not latched");
  AST_RSV_ALERT:
    assert property (reg_rd && reg_addr == MAS_ADDR_ALERT_EN
      |=> !reg_rdata[4]) else $error("reserved enable bit set");
  AST_RSV_CFG:
    assert property (reg_rd && reg_addr == MAS_ADDR_PIN_CFG
      |=> !reg_rdata[0]) else $error("reserved config bit set");
  AST_PIN_OUT:
    assert property (!pin_one.out && !pin_two.out && !pin_three.out)
      else $error("pin driven high");
  AST_PIN3_FALL:
    assert property ($fell(pin_three.oe) |-> $past(reg_wr, 2))
      else $error("alert pin released without write");
  COV_ALERT: cover property (core_event.conv_done ##1 alert_pulse);
  COV_PIN3: cover property ($rose(pin_three.oe));
  COV_WAKE: cover property (shutdown && core_event.stuck_timeout);
endmodule : mas_alert_chk

// >>> bench/mas_host_model.sv
// Register host model driving the block's register port.
`timescale 1ns/1ps
module mas_host_model (
  // Clock
  input wire logic        core_clk,
  // Register port
  output logic [7:0]      reg_addr,
  output logic            reg_wr,
  output logic [7:0]      reg_wdata,
  output logic            reg_rd,
  input wire logic [7:0]  reg_rdata
);
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge core_clk);
    reg_wr = 1'b0;
  endtask : wr
  // Data is taken one cycle after the strobe, when the answer is valid.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge core_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge core_clk);
    reg_rd = 1'b0;
    d = reg_rdata;
  endtask : rd
endmodule : mas_host_model

// >>> bench/mas_alert_gpio_test.sv
// Self-checking bench for the alert and pin function block.
`timescale 1ns/1ps
module mas_alert_gpio_test;
  import mas_pkg::*;
  logic core_clk, rst_n, reg_wr, reg_rd, reg_rvalid, shutdown;
  logic accumulate_enable, alert_pulse, pin_one_in, pin_two_in;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, limit_compare;
  mas_event_type core_event;
  mas_pin_drive_type pin_one, pin_two, pin_three;
  int failures, tests_run;
  logic [7:0] ab [4] = '{8'h80, 8'h04, 8'h02, 8'h01};
  mas_event_type eb [4] = '{5'h10, 5'h04, 5'h02, 5'h01};
  mas_host_model host_u (.core_clk(core_clk), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata));
  mas_alert_gpio dut_u (.core_clk(core_clk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .limit_compare(limit_compare), .core_event(core_event),
    .shutdown(shutdown), .accumulate_enable(accumulate_enable),
    .alert_pulse(alert_pulse), .pin_one_in(pin_one_in),
    .pin_two_in(pin_two_in), .pin_three_in(1'b0), .pin_one(pin_one),
    .pin_two(pin_two), .pin_three(pin_three));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    host_u.rd(a, d);
    chk(d, e);
  endtask : rchk
  // Leaves the alert pulse due at return, the pin one cycle later.
  task automatic ev(input mas_event_type e);
    @(negedge core_clk);
    core_event = e;
    @(negedge core_clk);
    core_event = '0;
  endtask : ev
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : final_report
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  initial begin
    #200000;
    failures++;
    final_report();
  end
  initial begin
    rst_n = 1'b0;
    limit_compare = 8'h00;
    core_event = '0;
    pin_one_in = 1'b0;
    pin_two_in = 1'b1;
    repeat (3) @(negedge core_clk);
    rst_n = 1'b1;
    rchk(MAS_ADDR_FAULT, 8'h00);
    rchk(MAS_ADDR_ALERT_EN, 8'h00);
    rchk(MAS_ADDR_PIN_CFG, 8'h00);
    host_u.wr(8'h10, 8'hFF);
    rchk(8'h10, 8'h00);
    $display("reset values done");
    // Status is one cycle behind the compare, so let one edge pass first.
    limit_compare = 8'h82;
    @(negedge core_clk);
    rchk(MAS_ADDR_STATUS, 8'h82);
    limit_compare = 8'h00;
    @(negedge core_clk);
    rchk(MAS_ADDR_STATUS, 8'h00);
    rchk(MAS_ADDR_FAULT, 8'h82);
    host_u.wr(MAS_ADDR_FAULT, 8'h00);
    rchk(MAS_ADDR_FAULT, 8'h00);
    host_u.wr(MAS_ADDR_ALERT_EN, 8'hFF);
    rchk(MAS_ADDR_ALERT_EN, 8'hEF);
    host_u.wr(MAS_ADDR_PIN_CFG, 8'hFF);
    rchk(MAS_ADDR_PIN_CFG, 8'hFE);
    host_u.wr(MAS_ADDR_PIN_CFG, 8'h00);
    $display("register access done");
    for (int i = 0; i < 4; i++) begin
      host_u.wr(MAS_ADDR_ALERT_EN, ab[i]);
      ev(eb[i]);
      chk(alert_pulse, 8'h01);
      @(negedge core_clk);
      chk(pin_three.oe, 8'h01);
      host_u.wr(MAS_ADDR_PIN3_CTL, 8'h00);
    end
    host_u.wr(MAS_ADDR_ALERT_EN, 8'h7F);
    ev(eb[0]);
    chk(alert_pulse, 8'h00);
    host_u.wr(MAS_ADDR_CTRL_B, 8'h50);
    @(negedge core_clk);
    chk(shutdown, 8'h01);
    host_u.wr(MAS_ADDR_ALERT_EN, 8'h08);
    ev(5'h08);
    chk(alert_pulse, 8'h01);
    rchk(MAS_ADDR_CTRL_B, 8'h10);
    $display("event alerts done");
    host_u.wr(MAS_ADDR_PIN_CFG, 8'hC0);
    host_u.wr(MAS_ADDR_ALERT_EN, 8'h40);
    pin_one_in = 1'b1;
    @(negedge core_clk);
    chk(alert_pulse, 8'h01);
    chk(pin_one.oe, 8'h00);
    pin_one_in = 1'b0;
    host_u.wr(MAS_ADDR_PIN_CFG, 8'h20);
    host_u.wr(MAS_ADDR_ALERT_EN, 8'h20);
    pin_two_in = 1'b0;
    @(negedge core_clk);
    chk(alert_pulse, 8'h01);
    pin_two_in = 1'b1;
    host_u.wr(MAS_ADDR_PIN_CFG, 8'h12);
    @(negedge core_clk);
    chk(pin_two.oe, 8'h01);
    host_u.wr(MAS_ADDR_PIN_CFG, 8'h04);
    host_u.wr(MAS_ADDR_PIN3_CTL, 8'h40);
    @(negedge core_clk);
    chk(pin_two.oe, 8'h00);
    chk(pin_three.oe, 8'h01);
    host_u.wr(MAS_ADDR_PIN_CFG, 8'h00);
    host_u.wr(MAS_ADDR_CTRL_B, 8'h08);
    repeat (2) @(negedge core_clk);
    chk(pin_one.oe, 8'h01);
    chk(accumulate_enable, 8'h01);
    $display("pin functions done");
    final_report();
  end
endmodule : mas_alert_gpio_test
bind mas_alert_gpio mas_alert_chk chk_u (.core_clk(core_clk), .rst_n(rst_n),
  .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
  .limit_compare(limit_compare), .core_event(core_event),
  .shutdown(shutdown), .accumulate_enable(accumulate_enable),
  .alert_pulse(alert_pulse), .pin_one_in(pin_one_in),
  .pin_two_in(pin_two_in), .pin_three_in(pin_three_in),
  .pin_one(pin_one), .pin_two(pin_two), .pin_three(pin_three));
